// file: rtl/sacs_pkg.sv
// Constants for the chip-select readout of a 16-bit SAR converter.
// Assumes a 200 MHz core clock and a host-driven serial clock.
//
// Operation
// - Serial input high at start: chip-select
// - Serial input low at start: daisy-chain
// - Busy indicator adds one leading bit
// - Internal timer converts; serial clock only shifts
// - After conversion: acquire, power down, readable
// - Result is two's-complement differential code
// - 3-wire: start edge tri-states, samples, converts
// - Start falling edge drives MSB, then shifts
// - No busy: release after 16th falling edge
// - Busy: drive low at end, then shift
// - Busy: release after 17th falling edge
// - 4-wire: start edge with input high converts
// - Conversion ignores serial input level
// - Input falling edge drives MSB, then shifts

`default_nettype none

package sacs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CORE_CLK_MHZ   = 200;   // Core clock rate
    localparam int T_CONV_MIN_NS  = 500;   // Shortest conversion
    localparam int T_CONV_MAX_NS  = 1300;  // Longest conversion
    localparam int NS_PER_US      = 1000;  // Unit scale
    // Least time rounds up, longest rounds down
    localparam int CONV_MIN_CYC =
        (T_CONV_MIN_NS * CORE_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int CONV_MAX_CYC = (T_CONV_MAX_NS * CORE_CLK_MHZ) / NS_PER_US;

    ////////////////////////////////////////////////////////////////////////
    // Widths and fixed values
    localparam int RES_BITS_DEF = 16;      // Result width
    localparam int CONV_CNT_W   = 9;       // Conversion timer width
    localparam int EDGE_CNT_W   = 8;       // Serial clock edge counter
    localparam int SYNC_PINS    = 2;       // Start and serial input
    localparam int PIN_START    = 0;       // Start pin index
    localparam int PIN_SIN      = 1;       // Serial input index
    localparam logic BUSY_LEVEL = 1'h0;    // Busy bit drives low

    // Controller states
    typedef enum logic [2:0] {
        SACS_IDLE,      // Nothing to read
        SACS_CONV,      // Converting on internal timer
        SACS_ACQ,       // Result held, waiting for chip select
        SACS_SHIFT      // Bits going out
    } sacs_state_e;

    // Binary to gray
    function automatic logic [EDGE_CNT_W-1:0] sacs_to_gray(
        input logic [EDGE_CNT_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray to binary
    function automatic logic [EDGE_CNT_W-1:0] sacs_from_gray(
        input logic [EDGE_CNT_W-1:0] g);
        logic [EDGE_CNT_W-1:0] b;
        b = g;
        for (int i = EDGE_CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

`default_nettype wire

// file: rtl/sacs_readout.sv
// Conversion sequencing and serial readout in chip-select mode.
// Assumes the host keeps its own timing; serial clock may stop outside reads.
// Result code comes from the array on the core clock; it needs no sync.

`default_nettype none

module sacs_readout
    import sacs_pkg::*;
#(
    parameter int RES_BITS  = RES_BITS_DEF,   // Result width
    parameter int CONV_CYC  = CONV_MAX_CYC    // Conversion length, cycles
) (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                link_sclk,
    input  wire logic                convert_start_pin,
    input  wire logic                serial_in_pin,
    input  wire logic [RES_BITS-1:0] sar_code,
    output var  logic                serial_out,
    output var  logic                serial_out_oe,
    output var  logic                converting,
    output var  logic                powered_down,
    output var  logic                cs_mode,
    output var  logic                busy_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // The timer must stop inside the allowed conversion window, and the
    // edge counter must hold a whole frame plus the busy bit without
    // wrapping past the base taken at frame start.
    generate
        if (CONV_CYC < CONV_MIN_CYC || CONV_CYC > CONV_MAX_CYC) begin : g_bad_conv
            $error("conversion length outside its bounds");
        end
        if (RES_BITS < 2 || RES_BITS + 1 >= (1 << EDGE_CNT_W)) begin : g_bad_res
            $error("result width not supported");
        end
    endgenerate

    // Timer end and frame lengths; a busy frame is one bit longer
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYC - 1);
    localparam logic [EDGE_CNT_W-1:0] LEN_PLAIN = EDGE_CNT_W'(RES_BITS);
    localparam logic [EDGE_CNT_W-1:0] LEN_BUSY  = EDGE_CNT_W'(RES_BITS + 1);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: counts serial clock falling edges in gray code.
    // Only a free count crosses; the core side takes a base at frame start,
    // so the count never needs clearing while the clock stands still.
    // Reset clears it at once, and again on any falling edge during reset;
    // waiting for edges would never end if the host parks the clock. A
    // release that meets an edge starts the count at zero or one, which the
    // relative base absorbs; no frame starts that close to reset.
    logic [EDGE_CNT_W-1:0] lk_gray_q;     // Edge count, gray
    logic [EDGE_CNT_W-1:0] lk_gray_d;     // Next edge count

    // Next count: one step per edge, one bit changes per step
    always_comb begin
        lk_gray_d = sacs_to_gray(sacs_from_gray(lk_gray_q) + 1'b1);
    end

    // Falling edges only: the host shifts on them
    always_ff @(negedge link_sclk or posedge reset) begin
        if (reset) begin
            // Constants only: nothing from the core domain is copied in
            lk_gray_q <= '0;
        end else begin
            lk_gray_q <= lk_gray_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain synchronisers: three stages, take when two and three agree
    // Both pins travel together so a 4-wire select and start are never
    // seen out of order. Stages reset high, the idle select level, so no
    // false select edge follows reset. The count word is taken only when
    // two stages agree; gray coding keeps any mix to one step off.
    logic [SYNC_PINS-1:0]  pin_s1_q, pin_s2_q, pin_s3_q;   // Pin stages
    logic [SYNC_PINS-1:0]  pin_f_q;                        // Filtered pins
    logic [SYNC_PINS-1:0]  pin_f_d;                        // Next filtered
    logic [EDGE_CNT_W-1:0] gr_s1_q, gr_s2_q, gr_s3_q;      // Count stages
    logic [EDGE_CNT_W-1:0] gr_f_q;                         // Filtered count
    logic [EDGE_CNT_W-1:0] gr_f_d;                         // Next count

    // Filters: a bit moves only when the last two stages agree, so a pin
    // caught mid-change is held off a cycle, never taken twice
    always_comb begin
        pin_f_d = pin_f_q;
        for (int i = 0; i < SYNC_PINS; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
                pin_f_d[i] = pin_s3_q[i];
            end
        end
        // Whole word must agree so no torn count is taken
        gr_f_d = (gr_s2_q == gr_s3_q) ? gr_s3_q : gr_f_q;
    end

    // Stages
    // During reset they hold the idle levels: select high, count zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            pin_s3_q <= '1;
            pin_f_q  <= '1;
            gr_s1_q  <= '0;
            gr_s2_q  <= '0;
            gr_s3_q  <= '0;
            gr_f_q   <= '0;
        end else begin
            pin_s1_q <= {serial_in_pin, convert_start_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q  <= pin_f_d;
            gr_s1_q  <= lk_gray_q;
            gr_s2_q  <= gr_s1_q;
            gr_s3_q  <= gr_s2_q;
            gr_f_q   <= gr_f_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin events
    // Edge detectors seed at the reset level of their filters, so the
    // first cycle after reset never shows an edge.
    logic start_lvl;        // Filtered start pin
    logic sin_lvl;          // Filtered serial input
    logic start_prev_q;     // Start pin one cycle ago
    logic sel_prev_q;       // Chip select one cycle ago
    logic start_rise;       // Start rising edge
    logic sel_low;          // Some chip-select line low
    logic sel_fall;         // Chip select just went low
    logic [EDGE_CNT_W-1:0] edges_now;   // Decoded edge count

    // In 3-wire the start pin is the select, in 4-wire the serial input;
    // the unused one sits high, so either low means selected.
    assign start_lvl  = pin_f_q[PIN_START];
    assign sin_lvl    = pin_f_q[PIN_SIN];
    assign sel_low    = ~(start_lvl & sin_lvl);
    assign start_rise = start_lvl & ~start_prev_q;
    assign sel_fall   = sel_low & ~sel_prev_q;
    assign edges_now  = sacs_from_gray(gr_f_q);

    // Edge history
    // One cycle of memory per detector
    always_ff @(posedge core_clk) begin
        if (reset) begin
            start_prev_q <= 1'h1;
            sel_prev_q   <= 1'h0;
        end else begin
            start_prev_q <= start_lvl;
            sel_prev_q   <= sel_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    // One frame at a time. The frame register holds the busy bit, if any,
    // above the result, so the bit on the line is always the top bit of
    // the frame shifted by the edges seen since the frame began. A shift
    // amount instead of a shifting register keeps all state in the core
    // domain; the price is a few core cycles from edge to new bit.
    sacs_state_e           state_q, state_d;        // Phase
    logic [CONV_CNT_W-1:0] conv_cnt_q, conv_cnt_d;  // Conversion timer
    logic                  cs_mode_q, cs_mode_d;    // Chip-select chosen
    logic                  busy_q, busy_d;          // Busy bit chosen
    logic [RES_BITS:0]     frame_q, frame_d;        // Output shift frame
    logic [EDGE_CNT_W-1:0] base_q, base_d;          // Edge count at start
    logic [EDGE_CNT_W-1:0] pos;                     // Bits already shifted
    logic [EDGE_CNT_W-1:0] frame_len;               // Bits in this frame
    logic [RES_BITS:0]     frame_sh;                // Frame at position
    logic                  out_q, out_d;            // Output bit
    logic                  oe_q, oe_d;              // Output drive

    // Same width on both sides, so the difference wraps cleanly
    assign pos       = edges_now - base_q;
    assign frame_len = busy_q ? LEN_BUSY : LEN_PLAIN;
    assign frame_sh  = frame_q << pos;

    // Next state
    // Every sequencer value holds unless a branch below changes it
    always_comb begin
        state_d    = state_q;
        conv_cnt_d = conv_cnt_q;
        cs_mode_d  = cs_mode_q;
        busy_d     = busy_q;
        frame_d    = frame_q;
        base_d     = base_q;
        out_d      = out_q;
        oe_d       = oe_q;
        // A start edge while converting is not a new sample: in 3-wire the
        // host may dip start to select other parts and must bring it back
        // before the shortest conversion ends
        if (start_rise && state_q != SACS_CONV) begin
            // New sample in any other phase; output released
            cs_mode_d  = sin_lvl;
            // Low input selects daisy-chain, left to its own logic
            state_d    = SACS_CONV;
            conv_cnt_d = '0;
            oe_d       = 1'h0;
            out_d      = 1'h1;
        end else begin
            unique case (state_q)
                SACS_IDLE: begin
                    // Line released, result spent or never made
                    oe_d = 1'h0;
                end
                SACS_CONV: begin
                    // Pins are read only in the last conversion cycle, to pick the frame
                    if (conv_cnt_q == CONV_LAST) begin
                        // Result held for reading
                        // Select level in the last cycle picks the frame:
                        // low means the host wants the busy bit
                        busy_d = sel_low;
                        frame_d = sel_low ? {BUSY_LEVEL, sar_code}
                                          : {sar_code, 1'h0};
                        // Daisy-chain: no chip-select frame here
                        if (!cs_mode_q) begin
                            state_d = SACS_IDLE;
                        end else if (sel_low) begin
                            // Busy bit at once, shifting follows
                            state_d = SACS_SHIFT;
                            base_d  = edges_now;
                            out_d   = BUSY_LEVEL;
                            oe_d    = 1'h1;
                        end else begin
                            state_d = SACS_ACQ;
                        end
                    end else begin
                        // Count on whatever the pins do
                        conv_cnt_d = conv_cnt_q + 1'b1;
                    end
                end
                SACS_ACQ: begin
                    // A select that never falls leaves the result unread
                    // Select falling drives the MSB
                    if (sel_fall) begin
                        state_d = SACS_SHIFT;
                        base_d  = edges_now;
                        out_d   = frame_q[RES_BITS];
                        oe_d    = 1'h1;
                    end
                end
                SACS_SHIFT: begin
                    if (!sel_low || pos >= frame_len) begin
                        // Deselect wins over a pending edge: host let go
                        // Release at last edge or deselect
                        state_d = SACS_IDLE;
                        oe_d    = 1'h0;
                        out_d   = 1'h1;
                    end else begin
                        out_d = frame_sh[RES_BITS];
                    end
                end
                default: begin
                    // Unused codes fall back to idle
                    state_d = SACS_IDLE;
                    oe_d    = 1'h0;
                end
            endcase
        end
    end

    // Registers
    // Reset leaves the line released and the pull-up level on the data bit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q    <= SACS_IDLE;
            conv_cnt_q <= '0;
            cs_mode_q  <= 1'h0;
            busy_q     <= 1'h0;
            frame_q    <= '0;
            base_q     <= '0;
            out_q      <= 1'h1;
            oe_q       <= 1'h0;
        end else begin
            state_q    <= state_d;
            conv_cnt_q <= conv_cnt_d;
            cs_mode_q  <= cs_mode_d;
            busy_q     <= busy_d;
            frame_q    <= frame_d;
            base_q     <= base_d;
            out_q      <= out_d;
            oe_q       <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // All come from flip-flops, two through a decode of the state; the host sees no combinational
    // path from its own pins.
    assign serial_out    = out_q;
    assign serial_out_oe = oe_q;
    assign converting    = (state_q == SACS_CONV);
    // Analog side idles outside conversion
    assign powered_down  = (state_q != SACS_CONV);
    assign cs_mode       = cs_mode_q;
    // Busy choice stands for the whole frame
    assign busy_mode     = busy_q;

endmodule

`default_nettype wire

// file: verif/sacs_readout_assertions.sv
// Checker for the chip-select readout: pin to output timing.
// Watches the readout ports only; bound in at the foot.
`default_nettype none
module sacs_readout_assertions
    import sacs_pkg::*;
#(
    parameter int CONV_CYC = CONV_MAX_CYC  // Conversion length, cycles
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic convert_start_pin,
    input wire logic serial_in_pin,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic converting,
    input wire logic powered_down,
    input wire logic cs_mode
);
    ////////////////////////////////////////////////////////////////////
    logic [9:0] cnt_q;  // Cycles spent converting
    logic [9:0] cnt_d;  // Next count
    // Count while converting, clear otherwise
    always_comb begin
        cnt_d = converting ? cnt_q + 10'h001 : 10'h000;
    end
    always_ff @(posedge core_clk) begin
        cnt_q <= reset ? 10'h000 : cnt_d;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Select, low if either pin is low: serves 3- and 4-wire hookups
    wire logic sel = convert_start_pin & serial_in_pin;
    ////////////////////////////////////////////////////////////////////
    property p_pd; powered_down == !converting; endproperty
    a_pd: assert property (p_pd) else $error("power state wrong");
    property p_len; $fell(converting) |-> cnt_q >= CONV_CYC - 2 && cnt_q <= CONV_CYC + 2;
    endproperty
    a_len: assert property (p_len) else $error("conversion length");
    property p_tri; $rose(convert_start_pin) |-> ##[1:8] converting && !serial_out_oe; endproperty
    a_tri: assert property (p_tri) else $error("start edge");
    property p_cs; $rose(convert_start_pin) && serial_in_pin |-> ##[1:8] cs_mode; endproperty
    a_cs: assert property (p_cs) else $error("select mode");
    property p_dc; $rose(convert_start_pin) && !serial_in_pin |-> ##[1:8] !cs_mode; endproperty
    a_dc: assert property (p_dc) else $error("chain mode");
    property p_busy; $fell(converting) && cs_mode && !sel |-> ##[0:3] serial_out_oe && !serial_out;
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit");
    property p_quiet; $fell(converting) && sel |-> !serial_out_oe [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("drove without select");
    property p_rel; $rose(sel) |-> ##[1:8] !serial_out_oe; endproperty
    a_rel: assert property (p_rel) else $error("no release");
    // Main scenarios reached
    c_busy: cover property ($fell(converting) && cs_mode && !sel);
    c_dc: cover property ($rose(convert_start_pin) && !serial_in_pin);
    c_rd: cover property ($fell(serial_out_oe));
endmodule
bind sacs_readout sacs_readout_assertions #(.CONV_CYC(CONV_CYC)) u_chk (
    .core_clk          (core_clk),
    .reset             (reset),
    .convert_start_pin (convert_start_pin),
    .serial_in_pin     (serial_in_pin),
    .serial_out        (serial_out),
    .serial_out_oe     (serial_out_oe),
    .converting        (converting),
    .powered_down      (powered_down),
    .cs_mode           (cs_mode)
);
`default_nettype wire

// file: verif/sacs_host_model.sv
// Host model: drives start, serial input and serial clock.
// Assumes a pull-up on the data line; the bench calls its tasks.
`default_nettype none
module sacs_host_model (
    input  wire logic core_clk,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    output var  logic convert_start_pin,
    output var  logic serial_in_pin,
    output var  logic link_sclk,
    output wire logic line
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released line floats up to the pull-up level
    assign line = serial_out_oe ? serial_out : 1'h1;
    // Idle: start low, input high, clock parked low
    initial begin
        convert_start_pin = 1'h0;
        serial_in_pin = 1'h1;
        link_sclk = 1'h0;
    end
    // Wait n core falling edges
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Both pins together; callers never lower both inside a frame
    task automatic pins(input logic s, input logic d);
        @(negedge core_clk);
        convert_start_pin = s;
        serial_in_pin = d;
    endtask
    // One 6 ns pulse, then the clock stands still while data settles
    task automatic pulse();
        @(negedge core_clk);
        #1.7 link_sclk = 1'h1;
        #6 link_sclk = 1'h0;
        wt(8);
    endtask
endmodule
`default_nettype wire

// file: verif/sacs_readout_tb.sv
// Bench for the chip-select readout: host scenarios, 3- and 4-wire.
// Assumes the host model and the bound checker.
`default_nettype none
module sacs_readout_tb;
    import sacs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk;  // 200 MHz
    logic        reset;     // Sync, high
    logic [15:0] sar_code;  // Array result
    int          err_total;
    int          tests_run;
    wire logic   link_sclk, convert_start_pin, serial_in_pin, line, serial_out;
    wire logic   serial_out_oe, converting, powered_down, cs_mode, busy_mode;
    sacs_readout dut (
        .core_clk          (core_clk),
        .reset             (reset),
        .link_sclk         (link_sclk),
        .convert_start_pin (convert_start_pin),
        .serial_in_pin     (serial_in_pin),
        .sar_code          (sar_code),
        .serial_out        (serial_out),
        .serial_out_oe     (serial_out_oe),
        .converting        (converting),
        .powered_down      (powered_down),
        .cs_mode           (cs_mode),
        .busy_mode         (busy_mode)
    );
    sacs_host_model h (
        .core_clk          (core_clk),
        .serial_out        (serial_out),
        .serial_out_oe     (serial_out_oe),
        .convert_start_pin (convert_start_pin),
        .serial_in_pin     (serial_in_pin),
        .link_sclk         (link_sclk),
        .line              (line)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic g, input logic e, input string m);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Bounded wait for the conversion to end
    task automatic wait_end();
        int i;
        for (i = 0; i < 400 && converting !== 1'h0; i++) begin
            h.wt(1);
        end
        if (i == 400) begin
            err_total++;
            $display("BAD %0t hung", $time);
            report_and_stop();
        end
    endtask
    // Start edge with select level d
    task automatic launch(input logic d, input logic [15:0] c);
        sar_code = c;
        h.pins(1'h0, d);
        h.wt(10);
        h.pins(1'h1, d);
        h.wt(12);
        chk(converting, 1'h1, "idle");
        chk(serial_out_oe, 1'h0, "driving");
        chk(cs_mode, d, "mode");
    endtask
    // n bits MSB first; the first is already on the line
    task automatic rd(input logic [15:0] c, input int n);
        for (int i = 0; i < n; i++) begin
            chk(line, c[15-i], "bit");
            h.pulse();
        end
    endtask
    // Raising start in 3-wire starts a conversion: let it finish
    task automatic settle();
        h.pins(1'h1, 1'h1);
        h.wt(12);
        wait_end();
    endtask
    ////////////////////////////////////////////////////////////////////
    // Start dips mid-conversion, then a full read
    task automatic t_3w_plain();
        launch(1'h1, 16'h8001);
        h.pins(1'h0, 1'h1);
        h.wt(20);
        chk(converting, 1'h1, "stopped");
        h.pins(1'h1, 1'h1);
        wait_end();
        h.wt(10);
        chk(serial_out_oe, 1'h0, "busy");
        h.pins(1'h0, 1'h1);
        h.wt(8);
        rd(16'h8001, 16);
        chk(serial_out_oe, 1'h0, "rel 16");
        settle();
    endtask
    // Busy bit, then 16 bits, released at 17th fall
    task automatic t_busy(input logic w3, input logic [15:0] c);
        launch(1'h1, c);
        h.pins(!w3, w3);
        wait_end();
        h.wt(4);
        chk(line, 1'h0, "no busy");
        chk(busy_mode, 1'h1, "mode");
        h.pulse();
        rd(c, 16);
        chk(serial_out_oe, 1'h0, "rel 17");
        settle();
    endtask
    // Input toggles mid-conversion; read cut short by select
    task automatic t_4w_abort();
        launch(1'h1, 16'hA5C3);
        h.pins(1'h1, 1'h0);
        h.wt(20);
        chk(converting, 1'h1, "stopped");
        h.pins(1'h1, 1'h1);
        wait_end();
        h.wt(10);
        chk(serial_out_oe, 1'h0, "busy");
        h.pins(1'h1, 1'h0);
        h.wt(8);
        rd(16'hA5C3, 5);
        h.pins(1'h1, 1'h1);
        h.wt(8);
        chk(serial_out_oe, 1'h0, "rel");
    endtask
    // Input low at start: chain mode, line left alone
    task automatic t_daisy();
        launch(1'h0, 16'h0F0F);
        wait_end();
        h.wt(20);
        chk(serial_out_oe, 1'h0, "chain");
        h.pins(1'h1, 1'h1);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'h0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        err_total = 0;
        tests_run = 0;
        reset = 1'h1;
        sar_code = 16'h0000;
        // Two serial clock edges inside the 20 reset cycles clear the link count
        h.pulse();
        h.pulse();
        h.wt(2);
        reset = 1'h0;
        h.wt(4);
        t_3w_plain();
        t_busy(1'h1, 16'h7FFE);
        t_4w_abort();
        t_busy(1'h0, 16'h3C5A);
        t_daisy();
        report_and_stop();
    end
endmodule
`default_nettype wire
